// [hdl/irq_wake_pkg.sv]
// Package: register map, field positions, timing and carrier types
package irq_wake_pkg;
  localparam logic [7:0] MON_CTRL_OFS = 8'h00;
  localparam logic [7:0] FLAGS_OFS = 8'h04;
  localparam logic [7:0] ENABLES_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam int THRESH_LSB = 0;
  localparam int THRESH_W = 3;
  localparam int DET_EN_BIT = 4;
  localparam int LOW_OUT_BIT = 5;
  localparam int FLAG_SERIAL_BIT = 0;
  localparam int FLAG_LOWSUP_BIT = 1;
  localparam int FLAG_GROUP_LSB = 8;
  localparam int FLAG_MEMBER_LSB = 16;
  localparam int EN_GLOBAL_BIT = 0;
  localparam int EN_SERIAL_BIT = 1;
  localparam int EN_GROUP_LSB = 8;
  localparam int STAT_WAKE_BIT = 0;
  localparam int STAT_SLEEP_BIT = 1;
  localparam logic [2:0] THRESH_RESET = 3'h0;
  localparam logic DET_EN_RESET = 1'b0;
  localparam int NUM_GROUPS = 7;
  localparam int LOW_SUPPLY_GROUP = 1;
  localparam int VEC_W = 4;
  localparam logic [VEC_W-1:0] VEC_SERIAL = 4'h0;
  localparam int CLK_MHZ = 125;
  localparam int DETECT_DELAY_NS = 100000;
  localparam int DETECT_CYCLES_DEF = (DETECT_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  typedef struct packed {
    logic valid;
    logic [VEC_W-1:0] vector;
  } core_call_t;
  typedef struct packed {
    logic sel;
    logic write;
    logic [7:0] addr;
  } bus_op_t;
endpackage

// [hdl/irq_wake_supply_monitor.sv]
// Interrupt flags, vectoring, wake-up and supply monitor with AHB-Lite slave
`timescale 1ns/1ps
// Functional notes
// - Serial-port event sets the serial-port request flag.
// - Serial vector called only if flag, global, serial enable set, stack not full.
// - Servicing serial clears its flag and the global enable.
// - Any flag rising low to high wakes, enables ignored.
// - Flag already high gives no wake; software may preset it.
// - Flags stay set until serviced or cleared by software.
// - Servicing a group clears only the group flag, not member flags.
// - Vectoring pushes only the program counter.
// - Interrupt return pops and sets global enable; plain return pops only.
// - Three-bit threshold select; every code selects the same level.
// - Monitor bit 5 reads 1 while the detector is enabled and supply is below threshold.
// - Monitor bit 4 enables the detector; 0 switches it off.
// - Monitor bits 7,6,3 read 0; implemented bits reset to 0.
// - Low-supply interrupt goes through one group interrupt.
// - Low-supply flag set only after detection delay of output high.
// - Enabled detector works asleep; a drop sets flag and wakes.
// - Output may toggle near threshold; no single clean edge assumed.
// - Group request raised when group flag set; members set group flags.
module irq_wake_supply_monitor import irq_wake_pkg::*; #(
  parameter int DETECT_CYCLES = DETECT_CYCLES_DEF
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic serial_event,
  input wire logic [NUM_GROUPS-1:0] member_event,
  input wire logic supply_below,
  input wire logic stack_full,
  input wire logic core_ready,
  input wire logic ret_irq_exec,
  input wire logic ret_plain_exec,
  input wire logic sleep_active,
  output core_call_t call,
  output logic push_pc,
  output logic pop_pc,
  output logic wake_req,
  output logic detector_on
);
  localparam int CNT_W = $clog2(DETECT_CYCLES + 1);
  localparam int ALL_W = 2 + 2 * NUM_GROUPS;

  bus_op_t op_reg;
  logic [2:0] threshold_select_reg;
  logic detector_enable_reg;
  logic low_out_reg;
  logic [CNT_W-1:0] det_cnt_reg;
  logic serial_flag_reg;
  logic lowsup_flag_reg;
  logic [NUM_GROUPS-1:0] group_flag_reg;
  logic [NUM_GROUPS-1:0] member_flag_reg;
  logic global_en_reg;
  logic serial_en_reg;
  logic [NUM_GROUPS-1:0] group_en_reg;
  logic [ALL_W-1:0] all_prev_reg;
  logic [ALL_W-1:0] all_flags;
  logic rise_any;
  logic wr_en, wr_mon, wr_flags, wr_en_reg_sel;
  logic lowsup_set;
  logic can_call, svc_serial;
  logic [NUM_GROUPS-1:0] svc_group;
  logic [NUM_GROUPS-1:0] group_set;
  logic [VEC_W-1:0] svc_vec;
  logic [31:0] rd_mux;
  logic access;

  // Bus address phase capture
  assign access = hsel & hready & htrans[1];
  assign wr_en = op_reg.sel & op_reg.write;
  assign wr_mon = wr_en & (op_reg.addr == MON_CTRL_OFS);
  assign wr_flags = wr_en & (op_reg.addr == FLAGS_OFS);
  assign wr_en_reg_sel = wr_en & (op_reg.addr == ENABLES_OFS);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      op_reg <= '0;
    end else begin
      op_reg <= '{sel: access, write: hwrite & (hsize == HSIZE_WORD), addr: haddr[7:0]};
    end
  end

  // Reads take one wait state so a write just before is always seen
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hrdata <= '0;
    end else begin
      hreadyout <= ~(access & ~hwrite);
      if (op_reg.sel & ~op_reg.write & ~hreadyout) begin
        hrdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  always_comb begin
    rd_mux = '0;
    case (op_reg.addr)
      MON_CTRL_OFS: begin
        rd_mux[THRESH_LSB +: THRESH_W] = threshold_select_reg;
        rd_mux[DET_EN_BIT] = detector_enable_reg;
        rd_mux[LOW_OUT_BIT] = low_out_reg;
      end
      FLAGS_OFS: begin
        rd_mux[FLAG_SERIAL_BIT] = serial_flag_reg;
        rd_mux[FLAG_LOWSUP_BIT] = lowsup_flag_reg;
        rd_mux[FLAG_GROUP_LSB +: NUM_GROUPS] = group_flag_reg;
        rd_mux[FLAG_MEMBER_LSB +: NUM_GROUPS] = member_flag_reg;
      end
      ENABLES_OFS: begin
        rd_mux[EN_GLOBAL_BIT] = global_en_reg;
        rd_mux[EN_SERIAL_BIT] = serial_en_reg;
        rd_mux[EN_GROUP_LSB +: NUM_GROUPS] = group_en_reg;
      end
      STATUS_OFS: begin
        rd_mux[STAT_WAKE_BIT] = wake_req;
        rd_mux[STAT_SLEEP_BIT] = sleep_active;
      end
      default: rd_mux = '0;
    endcase
  end

  // Threshold select stored only; all codes share one level
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      threshold_select_reg <= THRESH_RESET;
      detector_enable_reg <= DET_EN_RESET;
      detector_on <= DET_EN_RESET;
    end else begin
      if (wr_mon) begin
        threshold_select_reg <= hwdata[THRESH_LSB +: THRESH_W];
        detector_enable_reg <= hwdata[DET_EN_BIT];
      end
      detector_on <= wr_mon ? hwdata[DET_EN_BIT] : detector_enable_reg;
    end
  end

  // Output flag follows comparator while enabled
  // Delay restarts on every low, so chatter never shortens it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      low_out_reg <= 1'b0;
      det_cnt_reg <= '0;
    end else begin
      low_out_reg <= supply_below & detector_enable_reg;
      if (!low_out_reg) begin
        det_cnt_reg <= '0;
      end else if (det_cnt_reg != CNT_W'(DETECT_CYCLES)) begin
        det_cnt_reg <= det_cnt_reg + 1'b1;
      end
    end
  end

  // One set per high spell of the output
  assign lowsup_set = low_out_reg & (det_cnt_reg == CNT_W'(DETECT_CYCLES - 1));

  // Priority: serial first, then lowest group
  assign can_call = global_en_reg & ~stack_full & core_ready & ~call.valid;
  always_comb begin
    svc_serial = 1'b0;
    svc_group = '0;
    svc_vec = VEC_SERIAL;
    if (can_call & serial_flag_reg & serial_en_reg) begin
      svc_serial = 1'b1;
    end else if (can_call) begin
      for (int g = NUM_GROUPS - 1; g >= 0; g--) begin
        if (group_flag_reg[g] & group_en_reg[g]) begin
          svc_group = '0;
          svc_group[g] = 1'b1;
          svc_vec = VEC_W'(g + 1);
        end
      end
    end
  end

  // Serial flag; set wins over clears
  // Cleared only by service or software
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      serial_flag_reg <= 1'b0;
      lowsup_flag_reg <= 1'b0;
      member_flag_reg <= '0;
    end else begin
      serial_flag_reg <= ((wr_flags ? hwdata[FLAG_SERIAL_BIT] : serial_flag_reg) & ~svc_serial) | serial_event;
      // Detector path is level logic, active whatever the sleep state
      lowsup_flag_reg <= (wr_flags ? hwdata[FLAG_LOWSUP_BIT] : lowsup_flag_reg) | lowsup_set;
      // Member flags untouched by group service
      member_flag_reg <= (wr_flags ? hwdata[FLAG_MEMBER_LSB +: NUM_GROUPS] : member_flag_reg) | member_event;
    end
  end

  // Any member raising sets its group flag
  always_comb begin
    group_set = member_event;
    group_set[LOW_SUPPLY_GROUP] = member_event[LOW_SUPPLY_GROUP] | lowsup_set;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      group_flag_reg <= '0;
    end else begin
      group_flag_reg <= ((wr_flags ? hwdata[FLAG_GROUP_LSB +: NUM_GROUPS] : group_flag_reg) & ~svc_group)
                        | group_set;
    end
  end

  // Returns restore or leave global enable
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      global_en_reg <= 1'b0;
      serial_en_reg <= 1'b0;
      group_en_reg <= '0;
    end else begin
      if (wr_en_reg_sel) begin
        serial_en_reg <= hwdata[EN_SERIAL_BIT];
        group_en_reg <= hwdata[EN_GROUP_LSB +: NUM_GROUPS];
      end
      if (svc_serial | (|svc_group)) begin
        global_en_reg <= 1'b0;
      end else if (ret_irq_exec) begin
        global_en_reg <= 1'b1;
      end else if (wr_en_reg_sel) begin
        global_en_reg <= hwdata[EN_GLOBAL_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      call <= '0;
      push_pc <= 1'b0;
      pop_pc <= 1'b0;
    end else begin
      call.valid <= svc_serial | (|svc_group);
      call.vector <= svc_vec;
      push_pc <= svc_serial | (|svc_group);
      pop_pc <= ret_irq_exec | ret_plain_exec;
    end
  end

  // Rising edge of any flag, enables ignored
  // A flag held high shows no rise
  assign all_flags = {member_flag_reg, group_flag_reg, lowsup_flag_reg, serial_flag_reg};
  assign rise_any = |(all_flags & ~all_prev_reg);

  // Held until clock back, new rise wins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      all_prev_reg <= '0;
      wake_req <= 1'b0;
    end else begin
      all_prev_reg <= all_flags;
      wake_req <= rise_any | (wake_req & sleep_active);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_serial_set;
    serial_event |=> serial_flag_reg;
  endproperty
  a_serial_set: assert property (p_serial_set) else $error("serial event lost");

  property p_call_cond;
    call.valid && call.vector == VEC_SERIAL |-> $past(global_en_reg && serial_en_reg && !stack_full);
  endproperty
  a_call_cond: assert property (p_call_cond) else $error("call without enables");

  property p_svc_clear;
    call.valid |-> !global_en_reg;
  endproperty
  a_svc_clear: assert property (p_svc_clear) else $error("global enable not cleared");

  property p_wake_rise;
    $rose(serial_flag_reg) |=> wake_req;
  endproperty
  a_wake_rise: assert property (p_wake_rise) else $error("no wake on rise");

  property p_no_spurious;
    $rose(wake_req) |-> $past(rise_any);
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("wake without rise");

  property p_persist;
    $fell(serial_flag_reg) |-> $past(svc_serial || wr_flags);
  endproperty
  a_persist: assert property (p_persist) else $error("flag dropped");

  property p_member_keep;
    (|svc_group) && !wr_flags |=> (member_flag_reg & $past(member_flag_reg)) == $past(member_flag_reg);
  endproperty
  a_member_keep: assert property (p_member_keep) else $error("member flag cleared");

  property p_return_from_interrupt;
    ret_irq_exec && !svc_serial && !(|svc_group) |=> global_en_reg && pop_pc;
  endproperty
  a_return_from_interrupt: assert property (p_return_from_interrupt) else $error("return did not restore");

  property p_ret_plain;
    ret_plain_exec && !ret_irq_exec && !global_en_reg && !wr_en_reg_sel |=> !global_en_reg && pop_pc;
  endproperty
  a_ret_plain: assert property (p_ret_plain) else $error("plain return set enable");

  property p_det_off;
    !detector_enable_reg |=> !low_out_reg;
  endproperty
  a_det_off: assert property (p_det_off) else $error("detector not off");

  property p_detect_delay;
    $rose(lowsup_flag_reg) && !$past(wr_flags) |-> $past(low_out_reg) && $past(det_cnt_reg) == DETECT_CYCLES - 1;
  endproperty
  a_detect_delay: assert property (p_detect_delay) else $error("low-supply flag early");
endmodule

// [testbench/core_stack_model.sv]
// Core partner: return-address stack depth and full flag
`timescale 1ns/1ps
module core_stack_model #(
  parameter int DEPTH = 1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic push_pc,
  input wire logic pop_pc,
  output logic stack_full,
  output int level
);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      level <= 0;
    end else if (push_pc && !pop_pc) begin
      level <= level + 1;
    end else if (pop_pc && !push_pc && level > 0) begin
      level <= level - 1;
    end
  end
  assign stack_full = (level >= DEPTH);
endmodule

// [testbench/irq_wake_and_supply_monitor_tb.sv]
// Self-checking bench for flags, vectoring, wake-up and supply monitor
`timescale 1ns/1ps
module irq_wake_and_supply_monitor_tb import irq_wake_pkg::*;;
  localparam int DC = 8;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic serial_event = 1'b0, supply_below = 1'b0, stack_full, ret_irq_exec = 1'b0, ret_plain_exec = 1'b0;
  logic [NUM_GROUPS-1:0] member_event = 7'h00;
  logic sleep_active = 1'b0, push_pc, pop_pc, wake_req, detector_on;
  core_call_t call;
  int level, bad_count = 0, compares = 0, cyc = 0;
  // Single slave: its ready is the bus ready
  assign hready = hreadyout;
  irq_wake_supply_monitor #(.DETECT_CYCLES(DC)) u_irq_wake_supply_monitor (.sys_clk(sys_clk), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .serial_event(serial_event), .member_event(member_event),
    .supply_below(supply_below), .stack_full(stack_full), .core_ready(1'b1), .ret_irq_exec(ret_irq_exec),
    .ret_plain_exec(ret_plain_exec), .sleep_active(sleep_active), .call(call), .push_pc(push_pc), .pop_pc(pop_pc),
    .wake_req(wake_req), .detector_on(detector_on));
  core_stack_model #(.DEPTH(1)) u_core_stack_model (.sys_clk(sys_clk), .rst(rst), .push_pc(push_pc), .pop_pc(pop_pc),
    .stack_full(stack_full), .level(level));
  always #4 sys_clk = ~sys_clk;
  task automatic summarize;
    $display("Checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Hang guard, far above the expected run
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      summarize;
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, v);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, v);
    chk(what, exp, v);
    // Slave never answers with an error
    chk("okay response", 32'h0, {31'h0, hresp});
  endtask
  task automatic expect_call(input logic [VEC_W-1:0] vec);
    for (int i = 0; i < 20 && call.valid !== 1'b1; i++) @(posedge sys_clk);
    chk("call valid", 32'h1, {31'h0, call.valid});
    chk("call vector", {28'h0, vec}, {28'h0, call.vector});
    chk("push pc", 32'h1, {31'h0, push_pc});
  endtask
  task automatic no_call;
    logic seen;
    seen = 1'b0;
    repeat (8) begin
      @(posedge sys_clk);
      seen = seen | call.valid;
    end
    chk("refused call", 32'h0, {31'h0, seen});
  endtask
  task automatic t_reset;
    rd_chk("monitor reset", MON_CTRL_OFS, 32'h0);
    rd_chk("flags reset", FLAGS_OFS, 32'h0);
    chk("detector off", 32'h0, {31'h0, detector_on});
  endtask
  task automatic t_monitor;
    wr(MON_CTRL_OFS, 32'hffffffff);
    rd_chk("monitor all ones", MON_CTRL_OFS, 32'h17);
    chk("detector on", 32'h1, {31'h0, detector_on});
    wr(MON_CTRL_OFS, 32'h5);
    rd_chk("threshold code", MON_CTRL_OFS, 32'h5);
    chk("detector off", 32'h0, {31'h0, detector_on});
  endtask
  task automatic t_serial;
    serial_event <= 1'b1;
    tick(1);
    serial_event <= 1'b0;
    rd_chk("serial flag", FLAGS_OFS, 32'h1);
    no_call;
    rd_chk("flag kept", FLAGS_OFS, 32'h1);
    wr(ENABLES_OFS, 32'h3);
    expect_call(VEC_SERIAL);
    rd_chk("serial flag cleared", FLAGS_OFS, 32'h0);
    rd_chk("global cleared", ENABLES_OFS, 32'h2);
    chk("stack level", 32'h1, level);
    serial_event <= 1'b1;
    tick(1);
    serial_event <= 1'b0;
    wr(ENABLES_OFS, 32'h3);
    no_call;
    ret_irq_exec <= 1'b1;
    tick(1);
    ret_irq_exec <= 1'b0;
    expect_call(VEC_SERIAL);
    ret_plain_exec <= 1'b1;
    tick(1);
    ret_plain_exec <= 1'b0;
    tick(3);
    rd_chk("plain return", ENABLES_OFS, 32'h2);
    chk("stack popped", 32'h0, level);
  endtask
  task automatic t_wake;
    wr(ENABLES_OFS, 32'h0);
    wr(FLAGS_OFS, 32'h1);
    tick(3);
    chk("wake released", 32'h0, {31'h0, wake_req});
    sleep_active <= 1'b1;
    serial_event <= 1'b1;
    tick(1);
    serial_event <= 1'b0;
    tick(3);
    chk("no wake high flag", 32'h0, {31'h0, wake_req});
    member_event <= 7'h04;
    tick(1);
    member_event <= 7'h00;
    tick(2);
    chk("wake on rise", 32'h1, {31'h0, wake_req});
    sleep_active <= 1'b0;
    tick(3);
    chk("wake dropped", 32'h0, {31'h0, wake_req});
    rd_chk("group flags", FLAGS_OFS, 32'h00040401);
    wr(ENABLES_OFS, 32'h401);
    expect_call(4'h3);
    rd_chk("member kept", FLAGS_OFS, 32'h00040001);
    ret_irq_exec <= 1'b1;
    tick(1);
    ret_irq_exec <= 1'b0;
    rd_chk("return restores", ENABLES_OFS, 32'h401);
    wr(ENABLES_OFS, 32'h0);
    wr(FLAGS_OFS, 32'h0);
  endtask
  task automatic t_low_supply;
    wr(MON_CTRL_OFS, 32'h17);
    tick(4);
    sleep_active <= 1'b1;
    supply_below <= 1'b1;
    tick(3);
    rd_chk("low output", MON_CTRL_OFS, 32'h37);
    supply_below <= 1'b0;
    tick(DC + 4);
    rd_chk("toggle no flag", FLAGS_OFS, 32'h0);
    supply_below <= 1'b1;
    tick(DC - 5);
    rd_chk("before delay", FLAGS_OFS, 32'h0);
    tick(8);
    rd_chk("low supply flags", FLAGS_OFS, 32'h202);
    chk("wake asleep", 32'h1, {31'h0, wake_req});
    rd_chk("status asleep", STATUS_OFS, 32'h3);
    supply_below <= 1'b0;
    sleep_active <= 1'b0;
    wr(MON_CTRL_OFS, 32'h0);
    rd_chk("detector off", MON_CTRL_OFS, 32'h0);
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_reset;
    t_monitor;
    t_serial;
    t_wake;
    t_low_supply;
    summarize;
  end
endmodule
